/* File: logic/sec_pkg.sv */
package sec_pkg;

	// Control register location and bit positions
	localparam logic [7:0] SEC_CTRL_ADDR = 8'h40;
	localparam int         SEC_BIT_SEL   = 4;       // Memory select
	localparam int         SEC_BIT_SCK   = 5;       // Shift clock
	localparam int         SEC_BIT_SIN   = 6;       // Serial input
	localparam int         SEC_BIT_SOUT  = 7;       // Serial output
	localparam logic [3:0] SEC_CTRL_LOW  = 4'h0;    // Unused low bits read zero

	// Array geometry
	localparam int SEC_ADDR_W = 7;
	localparam int SEC_DATA_W = 8;
	localparam int SEC_DEPTH  = 128;

	// Erased byte value
	localparam logic [7:0] SEC_ERASED = 8'hFF;

	// Frame lengths after the start bit
	localparam logic [4:0] SEC_LEN_NODATA = 5'h09; // Opcode plus address
	localparam logic [4:0] SEC_LEN_DATA   = 5'h11; // Opcode, address, data

	// Main opcodes
	localparam logic [1:0] SEC_OP_EXT   = 2'h0;
	localparam logic [1:0] SEC_OP_WRITE = 2'h1;
	localparam logic [1:0] SEC_OP_READ  = 2'h2;
	localparam logic [1:0] SEC_OP_ERASE = 2'h3;

	// Extended codes carried in the two top address bits
	localparam logic [1:0] SEC_EXT_LOCK   = 2'h0; // write_lock_cmd
	localparam logic [1:0] SEC_EXT_WRITE_ALL_CMD   = 2'h1; // write_all_cmd
	localparam logic [1:0] SEC_EXT_ERASE_ALL_CMD   = 2'h2; // erase_all_cmd
	localparam logic [1:0] SEC_EXT_UNLOCK = 2'h3; // write_unlock_cmd

	// Programming time
	localparam int SEC_CLK_MHZ      = 50;
	localparam int SEC_PROG_TIME_US = 1000;
	localparam int SEC_PROG_CYCLES  = SEC_PROG_TIME_US * SEC_CLK_MHZ;

	// One programming job
	typedef struct packed {
		logic                  bulk; // Whole array
		logic [SEC_ADDR_W-1:0] addr; // Single target
		logic [SEC_DATA_W-1:0] data; // Byte to store
	} sec_job_t;

	// Programming engine states
	typedef enum logic {
		SEC_ENG_IDLE = 1'b0,
		SEC_ENG_PROG = 1'b1
	} sec_eng_t;

endpackage

/* File: logic/sec_mem.sv */
`timescale 1ns/1ns
module sec_mem #(
	parameter int AW = 7,
	parameter int DW = 8
) (
	input  wire logic          clk,
	input  wire logic          we,
	input  wire logic [AW-1:0] waddr,
	input  wire logic [DW-1:0] wdata,
	input  wire logic [AW-1:0] raddr,
	output logic      [DW-1:0] rdata
);
	// Storage array
	logic [DW-1:0] mem [0:(1<<AW)-1];

	// Write port and registered read port
	always_ff @(posedge clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
		rdata <= mem[raddr];
	end
endmodule

/* File: logic/sec_ctrl.sv */
`timescale 1ns/1ns
//
// Overview of operation
// - Erase-all sets every array bit to one
// - Erase-all begins when select falls
// - Write-all overwrites without prior erase
// - Write-all commits byte everywhere on select fall
// - Erase frame: start, 11, address MSB first
// - Single erase happens on select fall
// - Programming self-timed by counting system clock cycles
// - Commands ignored while programming runs
// - Serial output low busy, high done
// - Control register 40H bits 4..7 mapped
// - Serial input sampled on shift clock rise
// - Unlock holds until lock or reset
module sec_ctrl
	import sec_pkg::*;
#(
	parameter int PROG_CYCLES = sec_pkg::SEC_PROG_CYCLES
) (
	input  wire logic                           sys_clk,
	input  wire logic                           resetn,
	input  wire logic                           reg_wr,
	input  wire logic [7:0]                     reg_addr,
	input  wire logic [7:0]                     reg_wdata,
	output logic      [7:0]                     reg_rdata,
	input  wire logic [sec_pkg::SEC_ADDR_W-1:0] dbg_addr,
	output logic      [sec_pkg::SEC_DATA_W-1:0] dbg_data
);
	import sec_pkg::*;

	// Timer geometry, long enough to sweep the whole array
	localparam int             TW        = $clog2(PROG_CYCLES + 1);
	localparam logic [TW-1:0]  TMR_LAST  = TW'(PROG_CYCLES - 1);
	localparam logic [TW-1:0]  TMR_DEPTH = TW'(SEC_DEPTH);
	localparam logic [TW-1:0]  TMR_ONE   = TW'(1);
	localparam logic [4:0]     BIT_ONE   = 5'h01;
	localparam logic [1:0]     FIFO_FULL = 2'h2;

	// Whole state of the block
	typedef struct packed {
		logic                  sel;      // Memory select bit
		logic                  sck;      // Shift clock bit
		logic                  sin;      // Serial input bit
		logic                  sel_prev; // Select one cycle ago
		logic                  sck_prev; // Shift clock one cycle ago
		logic                  started;  // Start bit seen
		logic [4:0]            nbits;    // Bits after start
		logic [16:0]           shreg;    // Received bits
		logic                  unlocked; // Erase/write permitted
		sec_job_t [1:0]        fifo;     // Two-entry job buffer
		logic                  fifo_wp;  // Buffer write slot
		logic                  fifo_rp;  // Buffer read slot
		logic [1:0]            fifo_cnt; // Buffer fill
		sec_eng_t              eng;      // Engine state
		logic [TW-1:0]         timer;    // Programming time
		sec_job_t              cur;      // Job being programmed
		logic                  mem_we;   // Array write strobe
		logic [SEC_ADDR_W-1:0] mem_addr; // Array write address
		logic [SEC_DATA_W-1:0] mem_data; // Array write data
		logic                  sout;     // Serial output bit
		logic [7:0]            rdata;    // Register read data
	} sec_state_t;

	sec_state_t s_r;   // Registered state
	sec_state_t s_nxt; // Next state

	logic [1:0] rst_pipe_r; // Reset release synchroniser
	logic       rst_n;      // Synchronised reset

	// Reset release through two flops
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			rst_pipe_r <= 2'h0;
		end else begin
			rst_pipe_r <= {rst_pipe_r[0], 1'b1};
		end
	end
	assign rst_n = rst_pipe_r[1];

	// Decode helpers
	logic                  busy;     // Job pending or running
	logic                  sck_rise; // Shift clock rising edge
	logic                  sel_fall; // Select falling edge
	logic [1:0]            f_op;     // Received opcode
	logic [SEC_ADDR_W-1:0] f_addr;   // Received address
	logic [SEC_DATA_W-1:0] f_data;   // Received data
	logic                  len_nd;   // Frame without data complete
	logic                  len_d;    // Frame with data complete
	logic                  push;     // Enqueue a job
	logic                  pop;      // Dequeue a job
	sec_job_t              new_job;  // Job to enqueue

	// Next-state logic
	always_comb begin
		s_nxt    = s_r;
		s_nxt.mem_we = 1'b0;
		push     = 1'b0;
		pop      = 1'b0;
		new_job  = '0;
		busy     = (s_r.eng == SEC_ENG_PROG) || (s_r.fifo_cnt != 2'h0);
		sck_rise = s_r.sck && !s_r.sck_prev;
		sel_fall = s_r.sel_prev && !s_r.sel;
		len_nd   = (s_r.nbits == SEC_LEN_NODATA);
		len_d    = (s_r.nbits == SEC_LEN_DATA);

		// Field extraction depends on frame length
		if (len_d) begin
			f_op   = s_r.shreg[16:15];
			f_addr = s_r.shreg[14:8];
			f_data = s_r.shreg[7:0];
		end else begin
			f_op   = s_r.shreg[8:7];
			f_addr = s_r.shreg[6:0];
			f_data = SEC_ERASED;
		end

		// Firmware writes the control bits
		if (reg_wr && (reg_addr == SEC_CTRL_ADDR)) begin
			s_nxt.sel = reg_wdata[SEC_BIT_SEL];
			s_nxt.sck = reg_wdata[SEC_BIT_SCK];
			s_nxt.sin = reg_wdata[SEC_BIT_SIN];
		end
		s_nxt.sel_prev = s_r.sel;
		s_nxt.sck_prev = s_r.sck;

		// Serial receiver
		if (!s_r.sel) begin
			// Deselected: frame discarded
			s_nxt.started = 1'b0;
			s_nxt.nbits   = 5'h00;
		end else if (sck_rise && !busy) begin
			if (!s_r.started) begin
				// Leading zeros skipped until start bit
				s_nxt.started = s_r.sin;
			end else if (s_r.nbits != SEC_LEN_DATA) begin
				// MSB-first shift of opcode, address, data
				s_nxt.shreg = {s_r.shreg[15:0], s_r.sin};
				s_nxt.nbits = s_r.nbits + BIT_ONE;
			end
		end

		// Command executes on select falling edge
		if (sel_fall && s_r.started && !busy) begin
			case (f_op)
				SEC_OP_EXT: begin
					case (f_addr[6:5])
						SEC_EXT_UNLOCK: begin
							// Unlock sticks until lock or reset
							if (len_nd) begin
								s_nxt.unlocked = 1'b1;
							end
						end
						SEC_EXT_LOCK: begin
							if (len_nd) begin
								s_nxt.unlocked = 1'b0;
							end
						end
						SEC_EXT_ERASE_ALL_CMD: begin
							// Whole array to ones
							new_job = '{bulk: 1'b1, addr: '0, data: SEC_ERASED};
							push    = len_nd && s_r.unlocked;
						end
						default: begin
							// Whole array to one byte
							new_job = '{bulk: 1'b1, addr: '0, data: f_data};
							push    = len_d && s_r.unlocked;
						end
					endcase
				end
				SEC_OP_WRITE: begin
					// Single byte write
					new_job = '{bulk: 1'b0, addr: f_addr, data: f_data};
					push    = len_d && s_r.unlocked;
				end
				SEC_OP_ERASE: begin
					// Single byte to ones
					new_job = '{bulk: 1'b0, addr: f_addr, data: SEC_ERASED};
					push    = len_nd && s_r.unlocked;
				end
				default: begin
					// Read not handled here
					push = 1'b0;
				end
			endcase
		end

		// Buffer back-pressure: no push when full
		if (s_r.fifo_cnt == FIFO_FULL) begin
			push = 1'b0;
		end
		if (push) begin
			s_nxt.fifo[s_r.fifo_wp] = new_job;
			s_nxt.fifo_wp           = !s_r.fifo_wp;
		end

		// Self-timed programming engine
		case (s_r.eng)
			SEC_ENG_IDLE: begin
				if (s_r.fifo_cnt != 2'h0) begin
					pop           = 1'b1;
					s_nxt.cur     = s_r.fifo[s_r.fifo_rp];
					s_nxt.fifo_rp = !s_r.fifo_rp;
					s_nxt.timer   = '0;
					s_nxt.eng     = SEC_ENG_PROG;
				end
			end
			SEC_ENG_PROG: begin
				// Bulk jobs sweep one address per cycle
				if (s_r.cur.bulk) begin
					s_nxt.mem_we   = (s_r.timer < TMR_DEPTH);
					s_nxt.mem_addr = s_r.timer[SEC_ADDR_W-1:0];
				end else begin
					s_nxt.mem_we   = (s_r.timer == '0);
					s_nxt.mem_addr = s_r.cur.addr;
				end
				s_nxt.mem_data = s_r.cur.data;
				s_nxt.timer    = s_r.timer + TMR_ONE;
				if (s_r.timer == TMR_LAST) begin
					s_nxt.eng = SEC_ENG_IDLE;
				end
			end
			default: begin
				s_nxt.eng = SEC_ENG_IDLE;
			end
		endcase

		// Buffer fill count
		if (push && !pop) begin
			s_nxt.fifo_cnt = s_r.fifo_cnt + 2'h1;
		end else if (pop && !push) begin
			s_nxt.fifo_cnt = s_r.fifo_cnt - 2'h1;
		end

		// Ready indication on serial output
		s_nxt.sout = !busy;

		// Registered read of the control register
		if (reg_addr == SEC_CTRL_ADDR) begin
			s_nxt.rdata = {s_r.sout, s_r.sin, s_r.sck, s_r.sel, SEC_CTRL_LOW};
		end else begin
			s_nxt.rdata = 8'h00;
		end
	end

	// State register
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_r      <= '0;
			s_r.sout <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	// Data array
	sec_mem #(
		.AW (SEC_ADDR_W),
		.DW (SEC_DATA_W)
	) u_mem (
		.clk   (sys_clk),
		.we    (s_r.mem_we),
		.waddr (s_r.mem_addr),
		.wdata (s_r.mem_data),
		.raddr (dbg_addr),
		.rdata (dbg_data)
	);

	// Register outputs
	assign reg_rdata = s_r.rdata;

endmodule

/* File: tb/sec_fw.sv */
`timescale 1ns/1ns
module sec_fw (
	input  wire logic       sys_clk,
	output logic            reg_wr,
	output logic      [7:0] reg_addr,
	output logic      [7:0] reg_wdata,
	input  wire logic [7:0] reg_rdata
);
	// Idle bus points at the control register
	initial begin
		reg_wr    = 1'b0;
		reg_addr  = 8'h40;
		reg_wdata = 8'h00;
	end
	// One store, then a gap so the device sees each edge
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge sys_clk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= v;
		@(posedge sys_clk);
		reg_wr    <= 1'b0;
		reg_addr  <= 8'h40;
		@(posedge sys_clk);
	endtask
	// Select, then top n bits MSB first, then select low
	task automatic send(input logic [17:0] f, input int n);
		wr(8'h40, 8'h10);
		for (int i = 17; i > 17 - n; i--) begin
			wr(8'h40, {1'b0, f[i], 2'b01, 4'h0});
			wr(8'h40, {1'b0, f[i], 2'b11, 4'h0});
		end
		wr(8'h40, 8'h00);
	endtask
	// Raise select and count cycles until ready, no shift clock
	task automatic poll(output int n);
		wr(8'h40, 8'h10);
		// Look at read data only once it has settled
		@(negedge sys_clk);
		n = 0;
		while (reg_rdata[7] !== 1'b1 && n < 400) begin
			@(negedge sys_clk);
			n++;
		end
	endtask
endmodule

/* File: tb/sec_ctrl_chk.sv */
`timescale 1ns/1ns
module sec_ctrl_chk #(
	parameter int PROG_CYCLES = 200
) (
	input wire logic       sys_clk,
	input wire logic       resetn,
	input wire logic       reg_wr,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata
);
	logic       wr_ctl;   // Store to control register
	logic [7:0] addr_q;   // Address behind read data
	logic [9:0] low_cnt;  // Busy cycles seen
	logic [7:0] sel0_age; // Cycles since select written low
	assign wr_ctl = reg_wr && reg_addr == 8'h40;
	// Helper counters
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			addr_q   <= 8'h00;
			low_cnt  <= 10'h000;
			sel0_age <= 8'hFF;
		end else begin
			addr_q   <= reg_addr;
			low_cnt  <= (addr_q == 8'h40 && !reg_rdata[7]) ? low_cnt + 10'h001 : 10'h000;
			sel0_age <= (wr_ctl && !reg_wdata[4]) ? 8'h00 : sel0_age + {7'h00, sel0_age != 8'hFF};
		end
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!resetn);
	AST_RD_OTHER: assert property (reg_addr != 8'h40 |=> reg_rdata == 8'h00)
		else $error("unmapped read not zero");
	AST_LOW_ZERO: assert property (reg_addr == 8'h40 |=> reg_rdata[3:0] == 4'h0)
		else $error("unused control bits not zero");
	AST_CTRL_ECHO: assert property (wr_ctl ##1 (!reg_wr && reg_addr == 8'h40)
		|=> reg_rdata[6:4] == $past(reg_wdata[6:4], 2)) else $error("control bits wrong");
	AST_CTRL_HOLD: assert property ((!reg_wr && reg_addr == 8'h40)[*2]
		|=> reg_rdata[6:4] == $past(reg_rdata[6:4])) else $error("control bits moved");
	AST_WR_OTHER: assert property ((!reg_wr && reg_addr == 8'h40) ##1 (reg_wr && reg_addr != 8'h40)
		##1 (!reg_wr && reg_addr == 8'h40) |=> reg_rdata[6:4] == $past(reg_rdata[6:4], 2))
		else $error("unmapped write changed control");
	AST_BUSY_LEN: assert property (($rose(reg_rdata[7]) && low_cnt > 10'h008)
		|-> low_cnt >= PROG_CYCLES - 2 && low_cnt <= PROG_CYCLES + 6) else $error("busy length");
	AST_BUSY_START: assert property (($fell(reg_rdata[7]) && addr_q == 8'h40
		&& $past(addr_q) == 8'h40) |-> sel0_age >= 8'h02 && sel0_age <= 8'h08)
		else $error("busy without select fall");
	AST_RST_IDLE: assert property (($rose(resetn) && reg_addr == 8'h40)
		|-> ##4 reg_rdata == 8'h80) else $error("not idle after reset");
endmodule
bind sec_ctrl sec_ctrl_chk #(.PROG_CYCLES(PROG_CYCLES)) sec_ctrl_chk_inst (
	.sys_clk(sys_clk), .resetn(resetn), .reg_wr(reg_wr), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

/* File: tb/test_sec_ctrl.sv */
`timescale 1ns/1ns
module test_sec_ctrl;
	import sec_pkg::*;
	localparam int PC = 200; // Short programming time
	logic       sys_clk;
	logic       resetn;
	logic       reg_wr;
	logic [7:0] reg_addr;
	logic [7:0] reg_wdata;
	logic [7:0] reg_rdata;
	logic [6:0] dbg_addr;
	logic [7:0] dbg_data;
	int         fails;
	int         n_compared;
	int         n;
	sec_ctrl #(.PROG_CYCLES(PC)) sec_ctrl_inst (.sys_clk(sys_clk), .resetn(resetn),
		.reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .dbg_addr(dbg_addr), .dbg_data(dbg_data));
	sec_fw sec_fw_inst (.sys_clk(sys_clk), .reg_wr(reg_wr), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
	// Clock
	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end
	// Compare and count
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
		n_compared++;
		if (s !== e) begin
			$display("MISMATCH %s exp %h got %h", nm, e, s);
			fails++;
		end
	endtask
	// Verdict
	task automatic finish_test;
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// Backdoor array word
	task automatic mem(input logic [6:0] a, input logic [7:0] e);
		@(posedge sys_clk);
		dbg_addr <= a;
		@(posedge sys_clk);
		@(negedge sys_clk);
		chk("array", e, dbg_data);
	endtask
	// Poll for ready; busy cycles must lie in lo..hi
	task automatic bsy(input int lo, input int hi);
		sec_fw_inst.poll(n);
		n_compared++;
		if (n < lo || n > hi) begin
			$display("MISMATCH busy exp %0d..%0d got %0d", lo, hi, n);
			fails++;
		end
		if (n >= 400) finish_test();
	endtask
	// Frame with start bit
	function automatic logic [17:0] fr(logic [1:0] op, logic [6:0] a, logic [7:0] d);
		return {1'b1, op, a, d};
	endfunction
	// Main sequence
	initial begin
		fails = 0;
		n_compared = 0;
		resetn = 1'b0;
		dbg_addr = 7'h00;
		repeat (4) @(posedge sys_clk);
		resetn <= 1'b1;
		repeat (4) @(posedge sys_clk);
		@(negedge sys_clk);
		chk("ctrl", 8'h80, reg_rdata);
		sec_fw_inst.wr(8'h40, 8'h70);
		// Read data settles after the edge that launches it
		@(negedge sys_clk);
		chk("ctrl", 8'hF0, reg_rdata);
		sec_fw_inst.wr(8'h41, 8'h00);
		@(negedge sys_clk);
		chk("ctrl", 8'hF0, reg_rdata);
		sec_fw_inst.wr(8'h40, 8'h00);
		sec_fw_inst.send(fr(SEC_OP_EXT, {SEC_EXT_UNLOCK, 5'h00}, 8'h00), 10);
		sec_fw_inst.send(fr(SEC_OP_WRITE, 7'h7F, 8'h55), 18);
		bsy(PC - 30, PC + 10);
		sec_fw_inst.send(fr(SEC_OP_EXT, {SEC_EXT_LOCK, 5'h00}, 8'h00), 10);
		sec_fw_inst.send(fr(SEC_OP_EXT, {SEC_EXT_ERASE_ALL_CMD, 5'h1F}, 8'h00), 10);
		bsy(0, 0);
		mem(7'h7F, 8'h55);
		sec_fw_inst.send(fr(SEC_OP_EXT, {SEC_EXT_UNLOCK, 5'h1F}, 8'h00), 10);
		sec_fw_inst.send(fr(SEC_OP_EXT, {SEC_EXT_WRITE_ALL_CMD, 5'h0A}, 8'hA5), 18);
		sec_fw_inst.send(fr(SEC_OP_EXT, {SEC_EXT_ERASE_ALL_CMD, 5'h00}, 8'h00), 10);
		bsy(1, PC);
		mem(7'h00, 8'hA5);
		mem(7'h7F, 8'hA5);
		// Read opcode starts no programming cycle
		sec_fw_inst.send(fr(SEC_OP_READ, 7'h12, 8'h00), 18);
		bsy(0, 0);
		sec_fw_inst.send(fr(SEC_OP_ERASE, 7'h12, 8'h00), 10);
		bsy(PC - 30, PC + 10);
		mem(7'h12, 8'hFF);
		mem(7'h13, 8'hA5);
		sec_fw_inst.send(fr(SEC_OP_EXT, {SEC_EXT_ERASE_ALL_CMD, 5'h15}, 8'h00), 10);
		bsy(PC - 30, PC + 10);
		for (int a = 0; a < 128; a++) mem(a[6:0], 8'hFF);
		sec_fw_inst.send(fr(SEC_OP_EXT, {SEC_EXT_LOCK, 5'h00}, 8'h00), 10);
		sec_fw_inst.send(fr(SEC_OP_EXT, {SEC_EXT_WRITE_ALL_CMD, 5'h00}, 8'h00), 18);
		bsy(0, 0);
		mem(7'h05, 8'hFF);
		// Reset while the engine is idle: device comes back locked and idle
		@(posedge sys_clk);
		resetn <= 1'b0;
		repeat (4) @(posedge sys_clk);
		resetn <= 1'b1;
		repeat (4) @(posedge sys_clk);
		@(negedge sys_clk);
		chk("ctrl", 8'h80, reg_rdata);
		sec_fw_inst.send(fr(SEC_OP_EXT, {SEC_EXT_WRITE_ALL_CMD, 5'h00}, 8'h3C), 18);
		bsy(0, 0);
		mem(7'h40, 8'hFF);
		finish_test();
	end
endmodule
